// ---- core/psc_pkg.sv ----
// Shared constants and carriers of the pluggable module sideband control
// Notes on behaviour
// - The serial bus is answered only while module_select_n is held low.
// - A long enough low on module_reset_n returns all settings to defaults.
// - Reset completion drives interrupt_n low with init pending cleared.
// - Power-up posts the same completion interrupt with no reset pulse.
// - Power consumption is limited while low_power_select is high.
// - An inserted module pulls presence_n low.
// - interrupt_n goes low on a fault or critical status; faults on disabled channels or before init ends are masked.
// - interrupt_n is only ever pulled low, never driven high.
// - The memory map is read and written over serial clock and data.
// - Each of four channels is addressable and can be shut down.
// - Seven low-speed pins: select, clock, data, reset, power, presence, irq.
// - The module is fully functional within 2000 ms of power-up.
package psc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned INIT_MS      = 2000;
  localparam int unsigned INIT_CYC     = INIT_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_MIN_NS   = 10_000;
  localparam int unsigned RST_MIN_CYC  =
    (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ****************************************************************
  // Memory map
  // ****************************************************************
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_FLAGS    = 8'h01;
  localparam logic [7:0] OFS_CHAN_DIS = 8'h02;
  localparam logic [7:0] OFS_CTRL     = 8'h03;
  localparam logic [7:0] OFS_IDENT    = 8'h04;
  localparam logic [6:0] DEV_ADDR     = 7'h50;
  localparam logic [3:0] CHAN_DIS_RST = 4'h0;
  localparam logic       LP_FORCE_RST = 1'b0;
  localparam int unsigned NUM_CHAN    = 4;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [3:0] chan_dis;
    logic       lp_force;
  } psc_ctrl_s;

  typedef struct packed {
    logic       init_pending;
    logic       done_flag;
    logic [3:0] fault_flag;
  } psc_stat_s;

endpackage : psc_pkg

// ---- core/psc_sideband.sv ----
// Sideband pins, serial memory map and reset sequencing of the module
`timescale 1ns/10ps
module psc_sideband #(
  parameter int unsigned INIT_CYC    = psc_pkg::INIT_CYC,
  parameter int unsigned RST_MIN_CYC = psc_pkg::RST_MIN_CYC,
  parameter logic [7:0]  IDENT       = 8'h5a  // Arbitrary identity value
) (
  // System clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  // Host control pins
  input  wire logic       i_module_select_n,
  input  wire logic       i_module_reset_n,
  input  wire logic       i_low_power_select,
  // Serial bus
  input  wire logic       i_scl,
  input  wire logic       i_sda_in,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  // Open-collector outputs
  output logic            o_presence_out,
  output logic            o_presence_oe,
  output logic            o_interrupt_out,
  output logic            o_interrupt_oe,
  // Module core
  input  wire logic [3:0] i_fault,
  output logic [3:0]      o_chan_disable,
  output logic            o_power_limit,
  output logic            o_ready
);

  typedef enum logic [1:0] {ST_HOLD, ST_INIT, ST_RUN} psc_state_e;
  typedef enum logic [2:0] {LK_DEV, LK_PTR, LK_WR, LK_RD, LK_SKIP}
    psc_link_e;

  // ****************************************************************
  // System domain: pin synchronisers
  // ****************************************************************
  logic rn_m, rn_s, lp_m, lp_s;
  always_ff @(posedge i_sys_clk) begin
    rn_m <= i_module_reset_n;
    rn_s <= rn_m;
    lp_m <= i_low_power_select;
    lp_s <= lp_m;
  end

  // ****************************************************************
  // System domain: reset filter and init sequence
  // ****************************************************************
  localparam int RW = $clog2(RST_MIN_CYC + 1);
  localparam int IW = $clog2(INIT_CYC + 1);
  localparam logic [RW-1:0] RST_TOP = RW'(RST_MIN_CYC);
  localparam logic [IW-1:0] INIT_TOP = IW'(INIT_CYC - 1);

  logic [RW-1:0] rst_cnt;
  logic [IW-1:0] init_cnt;
  psc_state_e    state;
  logic          link_rst;
  wire           rst_hit   = !rn_s && (rst_cnt == RST_TOP);
  wire           init_end  = (state == ST_INIT) && (init_cnt == INIT_TOP);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || rn_s)
      rst_cnt <= '0;
    else if (rst_cnt != RST_TOP)
      rst_cnt <= rst_cnt + RW'(1);
  end

  // Power-up and a filtered reset pulse share one sequence
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || rst_hit) begin
      state    <= ST_HOLD;
      init_cnt <= '0;
      link_rst <= 1'b1;
    end else begin
      unique case (state)
        ST_HOLD: begin
          state    <= ST_INIT;
          link_rst <= 1'b0;
        end
        ST_INIT: begin
          init_cnt <= init_cnt + IW'(1);
          if (init_end)
            state <= ST_RUN;
        end
        ST_RUN: state <= ST_RUN;
      endcase
    end
  end

  // ****************************************************************
  // System domain: sticky flags and clear from the serial side
  // ****************************************************************
  psc_pkg::psc_ctrl_s ctrl, ctrl_s;
  logic [4:0] clr_mask, cm_m, cm_s;
  logic       clr_tgl, ct_m, ct_s, ct_d;
  logic       ctl_tgl, tg_m, tg_s, tg_d;
  logic       done_flag;
  logic [3:0] fault_flag;
  wire        clr_pulse = ct_s ^ ct_d;
  wire        ctl_pulse = tg_s ^ tg_d;
  wire        running   = (state == ST_RUN);
  wire [3:0]  fault_set = running ? (i_fault & ~ctrl_s.chan_dis) : 4'h0;
  wire [3:0]  fault_clr = clr_pulse ? cm_s[3:0] : 4'h0;
  wire        done_clr  = clr_pulse && cm_s[4];

  always_ff @(posedge i_sys_clk) begin
    tg_m   <= ctl_tgl;
    tg_s   <= tg_m;
    tg_d   <= tg_s;
    cm_m   <= clr_mask;
    cm_s   <= cm_m;
    ct_m   <= clr_tgl;
    ct_s   <= ct_m;
    ct_d   <= ct_s;
  end

  // A set in the same cycle as a clear wins
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || rst_hit) begin
      done_flag  <= 1'b0;
      fault_flag <= 4'h0;
      ctrl_s     <= '{chan_dis: psc_pkg::CHAN_DIS_RST,
                      lp_force: psc_pkg::LP_FORCE_RST};
    end else begin
      if (ctl_pulse)
        ctrl_s <= ctrl;
      done_flag  <= init_end || (done_flag && !done_clr);
      fault_flag <= fault_set | (fault_flag & ~fault_clr);
    end
  end

  // ****************************************************************
  // System domain: output pins
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_interrupt_oe <= 1'b0;
      o_chan_disable <= 4'hf;
      o_power_limit  <= 1'b1;
      o_ready        <= 1'b0;
      o_presence_oe  <= 1'b1;
    end else begin
      o_interrupt_oe <= done_flag || (|fault_flag);
      o_chan_disable <= running ? ctrl_s.chan_dis : 4'hf;
      o_power_limit  <= lp_s || ctrl_s.lp_force || !running;
      o_ready        <= running;
      o_presence_oe  <= 1'b1;
    end
  end

  // Open-collector lines only ever pull low
  always_ff @(posedge i_sys_clk) begin
    o_interrupt_out <= 1'b0;
    o_presence_out  <= 1'b0;
  end

  // ****************************************************************
  // Serial domain: status synchroniser
  // ****************************************************************
  psc_pkg::psc_stat_s stat, stat_m, stat_s;
  assign stat = '{init_pending: !running, done_flag: done_flag,
                  fault_flag: fault_flag};
  always_ff @(posedge i_scl) begin
    stat_m <= stat;
    stat_s <= stat_m;
  end

  // ****************************************************************
  // Serial domain: byte engine
  // ****************************************************************
  // Deselect ends the frame; no edge arrives after the host lets go
  wire        link_arst = i_module_select_n || link_rst;
  psc_link_e  lk;
  logic [3:0] bitc;
  logic [7:0] shreg, ptr, rd_byte;
  logic       ack_en;
  wire [7:0]  in_byte = {shreg[6:0], i_sda_in};
  wire        byte_end = (bitc == 4'd7);
  wire        ack_end  = (bitc == 4'd8);
  wire        dev_hit  = (in_byte[7:1] == psc_pkg::DEV_ADDR);

  wire [7:0] rd_mux =
    (ptr == psc_pkg::OFS_STATUS)   ? {6'h0, stat_s.init_pending,
                                      !stat_s.init_pending} :
    (ptr == psc_pkg::OFS_FLAGS)    ? {3'h0, stat_s.done_flag,
                                      stat_s.fault_flag} :
    (ptr == psc_pkg::OFS_CHAN_DIS) ? {4'h0, ctrl.chan_dis} :
    (ptr == psc_pkg::OFS_CTRL)     ? {7'h0, ctrl.lp_force} :
    (ptr == psc_pkg::OFS_IDENT)    ? IDENT : 8'h00;

  always_ff @(posedge i_scl or posedge link_arst) begin
    if (link_arst) begin
      lk      <= LK_DEV;
      bitc    <= 4'd0;
      shreg   <= 8'h00;
      ack_en  <= 1'b0;
      rd_byte <= 8'h00;
    end else begin
      bitc  <= ack_end ? 4'd0 : bitc + 4'd1;
      shreg <= in_byte;
      if (byte_end)
        ack_en <= (lk == LK_DEV) ? dev_hit :
                  (lk == LK_PTR || lk == LK_WR);
      if (ack_end) begin
        ack_en  <= 1'b0;
        rd_byte <= rd_mux;
        unique case (lk)
          LK_DEV:  lk <= !ack_en ? LK_SKIP :
                         (shreg[0] ? LK_RD : LK_PTR);
          LK_PTR:  lk <= LK_WR;
          LK_WR:   lk <= LK_WR;
          LK_RD:   lk <= LK_RD;
          LK_SKIP: lk <= LK_SKIP;
        endcase
      end
    end
  end

  // Pointer and writable registers keep their values across frames
  always_ff @(posedge i_scl or posedge link_rst) begin
    if (link_rst) begin
      ptr      <= 8'h00;
      ctrl     <= '{chan_dis: psc_pkg::CHAN_DIS_RST,
                    lp_force: psc_pkg::LP_FORCE_RST};
      clr_mask <= 5'h00;
      clr_tgl  <= 1'b0;
      ctl_tgl  <= 1'b0;
    end else if (!i_module_select_n) begin
      if (byte_end && lk == LK_PTR)
        ptr <= in_byte;
      if (byte_end && lk == LK_WR) begin
        ptr <= ptr + 8'h01;
        if (ptr == psc_pkg::OFS_CHAN_DIS)
          ctrl.chan_dis <= in_byte[3:0];
        if (ptr == psc_pkg::OFS_CTRL)
          ctrl.lp_force <= in_byte[0];
        if (ptr == psc_pkg::OFS_CHAN_DIS || ptr == psc_pkg::OFS_CTRL)
          ctl_tgl <= !ctl_tgl;
        if (ptr == psc_pkg::OFS_FLAGS) begin
          clr_mask <= in_byte[4:0];
          clr_tgl  <= !clr_tgl;
        end
      end
      if (byte_end && lk == LK_RD)
        ptr <= ptr + 8'h01;
    end
  end

  // Data changes while the clock is low
  wire rd_bit_low = (lk == LK_RD) && !ack_end && !rd_byte[3'(7 - bitc)];
  always_ff @(negedge i_scl or posedge link_arst) begin
    if (link_arst)
      o_sda_oe <= 1'b0;
    else
      o_sda_oe <= (ack_end && ack_en) || rd_bit_low;
  end

  always_ff @(negedge i_scl or posedge link_rst) begin
    if (link_rst)
      o_sda_out <= 1'b0;
    else
      o_sda_out <= 1'b0;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  property p_filter_short;
    running && rn_s ##1 !rn_s [*2] ##1 rn_s |-> state == $past(state, 3);
  endproperty
  a_filter_short: assert property (p_filter_short)
    else $error("Short reset pulse disturbed the module");

  property p_long_reset;
    rst_hit |=> state == ST_HOLD && link_rst;
  endproperty
  a_long_reset: assert property (p_long_reset)
    else $error("Filtered reset did not restart the module");

  property p_done_irq;
    init_end |=> done_flag ##1 o_interrupt_oe && o_ready;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("Reset completion did not raise the interrupt");

  property p_powerup;
    $fell(link_rst) |=> state == ST_INIT;
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("Power-up did not start the init sequence");

  property p_lowpower;
    lp_s |=> o_power_limit;
  endproperty
  a_lowpower: assert property (p_lowpower)
    else $error("Low power select ignored");

  property p_presence;
    o_presence_oe && !o_presence_out;
  endproperty
  a_presence: assert property (p_presence)
    else $error("Presence line not pulled low");

  property p_fault_irq;
    running && |(i_fault & ~ctrl_s.chan_dis) |=> ##1 o_interrupt_oe;
  endproperty
  a_fault_irq: assert property (p_fault_irq)
    else $error("Fault did not raise the interrupt");

  property p_open_coll;
    !o_interrupt_out;
  endproperty
  a_open_coll: assert property (p_open_coll)
    else $error("Interrupt line driven high");

  property p_chan_off;
    !running |=> o_chan_disable == 4'hf;
  endproperty
  a_chan_off: assert property (p_chan_off)
    else $error("Channel enabled before init finished");

  property p_init_len;
    $rose(running) |-> $past(state, 1) == ST_INIT;
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("Run entered without init");

  c_init: cover property (init_end);
  c_reset: cover property (rst_hit);
  c_clear: cover property (clr_pulse && done_flag);
  c_fault: cover property (|fault_flag);

endmodule : psc_sideband

// ---- tb/psc_host_model.sv ----
// Host board model: select line, serial bus master and line pull-ups
`timescale 1ns/10ps
module psc_host_model (
  // Serial bus
  output logic       o_select_n,
  output logic       o_scl,
  output wire logic  o_sda,
  input  wire logic  i_sda_oe,
  // Open-drain sideband lines
  input  wire logic  i_presence_oe,
  input  wire logic  i_interrupt_oe,
  output wire logic  o_presence_n,
  output wire logic  o_interrupt_n,
  // Read results
  output logic       o_rd_valid,
  output logic [7:0] o_rd_byte
);
  logic host_oe;

  // Released lines float to the pull-up, never to a held value
  assign o_sda         = ~(host_oe | i_sda_oe);
  assign o_presence_n  = ~i_presence_oe;
  assign o_interrupt_n = ~i_interrupt_oe;

  initial begin
    o_select_n = 1'b1;
    o_scl      = 1'b0;
    host_oe    = 1'b0;
    o_rd_valid = 1'b0;
    o_rd_byte  = 8'h00;
  end

  // ****************************************************************
  // One byte and its ack slot, MSB first; clock idles low
  // ****************************************************************
  task xfer(input logic [7:0] wb, input logic rd, output logic [7:0] rb,
            output logic ack);
    for (int i = 7; i >= 0; i--) begin
      host_oe = ~rd & ~wb[i];
      #8 o_scl = 1'b1;
      rb[i] = o_sda;
      #16 o_scl = 1'b0;
      #8;
    end
    host_oe = 1'b0;
    #8 o_scl = 1'b1;
    ack = ~o_sda;
    #16 o_scl = 1'b0;
    #8;
  endtask : xfer

  // Address byte, then one written or read byte, then an optional byte
  task frame(input logic sel, input logic [6:0] dev, input logic rd,
             input logic [7:0] b1, input logic two, input logic [7:0] b2,
             output logic ack);
    logic [7:0] rb;
    logic       a;
    o_select_n = ~sel;
    #64;
    xfer({dev, rd}, 1'b0, rb, ack);
    xfer(b1, rd, rb, a);
    ack = ack & (a | rd);
    if (rd) begin
      o_rd_byte = rb;
      o_rd_valid = 1'b1;
      #1 o_rd_valid = 1'b0;
    end
    if (two) begin
      xfer(b2, 1'b0, rb, a);
      ack = ack & a;
    end
    o_select_n = 1'b1;
    #64;
  endtask : frame
endmodule : psc_host_model

// ---- tb/testbench.sv ----
// Self-checking bench of the sideband control block
`timescale 1ns/10ps
module testbench;
  localparam int unsigned INIT = 50;
  localparam int unsigned RMIN = 4;
  logic        i_sys_clk, i_sys_rst, rst_n, lp, ack;
  logic [3:0]  fault;
  logic [31:0] lfsr = 32'h52e2;
  logic [7:0]  q[$];
  wire         select_n, scl, sda, sda_oe, pres_oe, irq_oe, rd_valid, sda_out;
  wire         presence_n, interrupt_n, power_limit, ready;
  wire  [3:0]  chan_dis;
  wire  [7:0]  rd_byte;
  int          miscompares = 0;
  int          n_tests = 0;

  psc_sideband #(.INIT_CYC(INIT), .RST_MIN_CYC(RMIN), .IDENT(8'h5a))
  i_psc_sideband (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_module_select_n(select_n), .i_module_reset_n(rst_n),
    .i_low_power_select(lp), .i_scl(scl), .i_sda_in(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_presence_out(),
    .o_presence_oe(pres_oe), .o_interrupt_out(), .o_interrupt_oe(irq_oe),
    .i_fault(fault), .o_chan_disable(chan_dis),
    .o_power_limit(power_limit), .o_ready(ready));

  psc_host_model u_host (
    .o_select_n(select_n), .o_scl(scl), .o_sda(sda), .i_sda_oe(sda_oe),
    .i_presence_oe(pres_oe), .i_interrupt_oe(irq_oe),
    .o_presence_n(presence_n), .o_interrupt_n(interrupt_n),
    .o_rd_valid(rd_valid), .o_rd_byte(rd_byte));

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] next_lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_lfsr

  task chk_bit(string name, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task chk_byte(string name, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte

  task cyc(int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : cyc

  task wr(logic [7:0] ofs, logic [7:0] data);
    u_host.frame(1'b1, psc_pkg::DEV_ADDR, 1'b0, ofs, 1'b1, data, ack);
    chk_bit("write ack", 1'b1, ack);
  endtask : wr

  // Pointer frame, then a read frame; the monitor checks the byte
  task rd(logic [7:0] ofs, logic [7:0] exp);
    u_host.frame(1'b1, psc_pkg::DEV_ADDR, 1'b0, ofs, 1'b0, 8'h00, ack);
    q.push_back(exp);
    u_host.frame(1'b1, psc_pkg::DEV_ADDR, 1'b1, 8'h00, 1'b0, 8'h00, ack);
    chk_bit("read ack", 1'b1, ack);
  endtask : rd

  task wait_ready();
    int k;
    k = 0;
    while (ready !== 1'b1 && k < INIT + 20) begin
      cyc(1);
      k++;
    end
    chk_bit("ready", 1'b1, ready);
  endtask : wait_ready

  task results();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  initial begin
    forever begin
      @(posedge rd_valid);
      chk_byte("read data", q.pop_front(), rd_byte);
    end
  end

  initial begin
    #1_000_000;
    miscompares++;
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    i_sys_rst = 1'b1;
    rst_n = 1'b1;
    lp = 1'b0;
    fault = 4'h0;
    cyc(4);
    i_sys_rst = 1'b0;
    chk_bit("presence_n", 1'b0, presence_n);
    chk_bit("ready", 1'b0, ready);
    cyc(3);
    rd(psc_pkg::OFS_STATUS, 8'h02);
    wait_ready();
    chk_bit("interrupt_n", 1'b0, interrupt_n);
    rd(psc_pkg::OFS_STATUS, 8'h01);
    rd(psc_pkg::OFS_IDENT, 8'h5a);
    rd(psc_pkg::OFS_FLAGS, 8'h10);
    wr(psc_pkg::OFS_FLAGS, 8'h10);
    cyc(10);
    chk_bit("interrupt_n", 1'b1, interrupt_n);
    // Foreign address and deselected traffic must leave no trace
    u_host.frame(1'b1, psc_pkg::DEV_ADDR ^ 7'h01, 1'b0,
                 psc_pkg::OFS_CHAN_DIS, 1'b1, 8'h0f, ack);
    chk_bit("foreign ack", 1'b0, ack);
    u_host.frame(1'b0, psc_pkg::DEV_ADDR, 1'b0,
                 psc_pkg::OFS_CHAN_DIS, 1'b1, 8'h0f, ack);
    chk_bit("deselected ack", 1'b0, ack);
    rd(psc_pkg::OFS_CHAN_DIS, 8'h00);
    lfsr = next_lfsr(lfsr);
    wr(psc_pkg::OFS_CHAN_DIS, {4'h0, lfsr[3:0]});
    cyc(6);
    chk_byte("chan_disable", {4'h0, lfsr[3:0]}, {4'h0, chan_dis});
    rd(psc_pkg::OFS_CHAN_DIS, {4'h0, lfsr[3:0]});
    for (int m = 0; m < 4; m++) begin
      cyc(1);
      lp = m[0];
      wr(psc_pkg::OFS_CTRL, {7'h00, m[1]});
      cyc(6);
      chk_bit("power_limit", logic'(m != 0), power_limit);
    end
    lp = 1'b0;
    wr(psc_pkg::OFS_CHAN_DIS, 8'h00);
    cyc(6);
    lfsr = next_lfsr(lfsr);
    fault = lfsr[3:0] | 4'h1;
    cyc(3);
    fault = 4'h0;
    cyc(3);
    chk_bit("interrupt_n", 1'b0, interrupt_n);
    rd(psc_pkg::OFS_FLAGS, {4'h0, lfsr[3:0] | 4'h1});
    wr(psc_pkg::OFS_FLAGS, 8'h1f);
    cyc(10);
    chk_bit("interrupt_n", 1'b1, interrupt_n);
    // A short low is filtered, a long one restores defaults
    wr(psc_pkg::OFS_CHAN_DIS, 8'h05);
    cyc(2);
    rst_n = 1'b0;
    cyc(RMIN - 2);
    rst_n = 1'b1;
    cyc(10);
    chk_bit("ready", 1'b1, ready);
    rd(psc_pkg::OFS_CHAN_DIS, 8'h05);
    cyc(2);
    rst_n = 1'b0;
    cyc(RMIN + 4);
    rst_n = 1'b1;
    chk_bit("ready", 1'b0, ready);
    wait_ready();
    chk_bit("interrupt_n", 1'b0, interrupt_n);
    rd(psc_pkg::OFS_CHAN_DIS, 8'h00);
    rd(psc_pkg::OFS_FLAGS, 8'h10);
    cyc(4);
    chk_byte("chan_disable", 8'h00, {4'h0, chan_dis});
    chk_bit("sda_out", 1'b0, sda_out);
    results();
  end
endmodule : testbench
